// ### rtl/isl_slave.v
/*
 * two-wire bus slave: address recognition (7 and 10 bit), byte
 * reception into a fifo-backed buffer register, byte transmission with
 * clock hold, acknowledge and slave event pulse.
 * assumes scl/sda are external open-drain lines sampled on CLK_IN and
 * a bus master driving serial clock well below CLK_IN / 8.
 */
//
// Function
// - full shift byte moves to buffer, pulse
// - transmit register single stage only
// - ten-bit own address register
// - select 0: compare low seven bits
// - select 1: 11110 plus top bits, low byte
// - reserved ranges; valid own addresses
// - idle until start, shift eight, compare
// - addr bits 6:0 vs shift 7:1, rw
// - sample data on serial clock rise
// - match: ack, event on ninth fall
// - address byte leaves buffer, full untouched
// - read direction: transmit, hold clock low (code holds it only while the transmit register is empty)
// - release bit frees clock, shift eight out
// - transmit data changes on falling edges
// - transmit pulse on ninth fall always
// - write direction: receive, load, ack
// - buffer full: no ack, pulse, no load
// - overflow without full: load, no ack
// - status low six bits read only
// - reload register feeds bit rate counter
// - repeated start in ten-bit: header only
// - ten-bit match flag update and pulses
`timescale 1ns/1ps
`include "isl_defines.vh"
module isl_slave #(
   parameter FIFO_DEPTH = `ISL_FIFO_DEPTH,
   parameter FIFO_AW    = 5
) (
   input  wire                     CLK_IN,
   input  wire                     ARST_N_IN,
   input  wire                     SCL_IN,
   output wire                     SCL_OUT,
   output wire                     SCL_OE_OUT,
   input  wire                     SDA_IN,
   output wire                     SDA_OUT,
   output wire                     SDA_OE_OUT,
   input  wire                     MODULE_ENABLE_BIT_IN,
   input  wire                     TEN_BIT_ADDR_SELECT_IN,
   input  wire [`ISL_ADDR_W-1:0]   OWN_ADDRESS_IN,
   input  wire                     OWN_ADDRESS_WR_IN,
   input  wire [`ISL_BRG_W-1:0]    BIT_RATE_RELOAD_IN,
   input  wire                     BIT_RATE_RELOAD_WR_IN,
   output wire                     BIT_RATE_TICK_OUT,
   input  wire [`ISL_BYTE_W-1:0]   TX_DATA_IN,
   input  wire                     TX_DATA_WR_IN,
   output wire                     TX_DATA_READY_OUT,
   input  wire                     CLOCK_RELEASE_SET_IN,
   output wire                     CLOCK_RELEASE_BIT_OUT,
   input  wire                     RX_OVERFLOW_CLR_IN,
   input  wire                     RX_BUFFER_RD_IN,
   output wire [`ISL_BYTE_W-1:0]   RX_BUFFER_OUT,
   output wire                     RX_BUFFER_FULL_FLAG_OUT,
   output wire                     RX_OVERFLOW_FLAG_OUT,
   output wire [`ISL_BYTE_W-1:0]   RX_STREAM_DATA_OUT,
   output wire                     RX_STREAM_VALID_OUT,
   input  wire                     RX_STREAM_READY_IN,
   output wire                     TX_BUFFER_FULL_OUT,
   output wire                     TEN_BIT_MATCH_FLAG_OUT,
   output wire                     READ_DIRECTION_OUT,
   output wire                     SLAVE_EVENT_IRQ_FLAG_OUT
);
   // state codes, one hot
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_ADDR = 6'h02;
   localparam [5:0] ST_ADLO = 6'h04;
   localparam [5:0] ST_RX   = 6'h08;
   localparam [5:0] ST_TX   = 6'h10;
   localparam [5:0] ST_WAIT = 6'h20;

   reg  [1:0]               scl_s;
   reg  [1:0]               sda_s;
   reg                      scl_d;
   reg                      sda_d;
   reg  [5:0]               state;
   reg  [3:0]               bit_cnt;
   reg  [`ISL_BYTE_W-1:0]   rx_shift_reg;
   reg  [`ISL_BYTE_W-1:0]   tx_shift;
   reg  [`ISL_BYTE_W-1:0]   tx_data_reg;
   reg                      tx_full;
   reg  [`ISL_ADDR_W-1:0]   own_address_reg;
   reg  [`ISL_BRG_W-1:0]    bit_rate_reload_reg;
   reg  [`ISL_BRG_W-1:0]    brg_cnt;
   reg  [`ISL_BYTE_W-1:0]   rx_buffer_reg;
   reg                      rx_buffer_full_flag;
   reg                      rx_overflow_flag;
   reg                      ten_bit_match_flag;
   reg                      clock_release_bit;
   reg                      rw_bit;
   reg                      ack_drive;
   reg                      sda_low;
   reg                      irq;
   reg                      hdr_seen;
   reg                      rx_load;
   reg                      rx_nack;
   reg                      master_nack;
   wire                     scl_rise;
   wire                     scl_fall;
   wire                     start_det;
   wire                     stop_det;
   wire [6:0]               a7;
   wire                     hit7;
   wire                     hit_hdr;
   wire                     hit_lo;
   wire                     fifo_ready;
   wire                     fifo_push;

   // =================================================================
   // pin synchronisers and edge detection
   // =================================================================
   // two flops on each line, third stage for edges
   always @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], SCL_IN};
         sda_s <= {sda_s[0], SDA_IN};
         scl_d <= scl_s[1];
         sda_d <= sda_s[1];
      end
   end

   assign scl_rise  = scl_s[1] & ~scl_d;
   assign scl_fall  = ~scl_s[1] & scl_d;
   assign start_det = scl_s[1] & scl_d & sda_d & ~sda_s[1];
   assign stop_det  = scl_s[1] & scl_d & ~sda_d & sda_s[1];

   // =================================================================
   // address compare
   // =================================================================
   // 7-bit compare, valid range only, 10-bit header compare
   assign a7   = rx_shift_reg[7:1];
   assign hit7 = ~TEN_BIT_ADDR_SELECT_IN &
                 (a7 == own_address_reg[6:0]) &
                 (a7 > `ISL_RSV_LO_MAX) & (a7 <= `ISL_VALID_HI);
   assign hit_hdr = TEN_BIT_ADDR_SELECT_IN &
                    (rx_shift_reg[7:3] == `ISL_TEN_HDR) &
                    (rx_shift_reg[2:1] == own_address_reg[9:8]);
   assign hit_lo  = (rx_shift_reg == own_address_reg[7:0]);

   // =================================================================
   // software-written registers
   // =================================================================
   // own address and bit rate reload
   always @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         own_address_reg     <= `ISL_OWN_ADDR_RST;
         bit_rate_reload_reg <= `ISL_BRG_RST;
         brg_cnt             <= `ISL_BRG_RST;
      end else begin
         if (OWN_ADDRESS_WR_IN) begin
            own_address_reg <= OWN_ADDRESS_IN;
         end
         if (BIT_RATE_RELOAD_WR_IN) begin
            bit_rate_reload_reg <= BIT_RATE_RELOAD_IN;
         end
         if (brg_cnt == {`ISL_BRG_W{1'b0}}) begin
            brg_cnt <= bit_rate_reload_reg;
         end else begin
            brg_cnt <= brg_cnt - 1'b1;
         end
      end
   end

   assign BIT_RATE_TICK_OUT = (brg_cnt == {`ISL_BRG_W{1'b0}});

   // =================================================================
   // slave protocol engine
   // =================================================================
   // one-hot machine on synchronised scl edges
   always @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state               <= ST_IDLE;
         bit_cnt             <= 4'h0;
         rx_shift_reg        <= 8'h00;
         tx_shift            <= 8'h00;
         tx_data_reg         <= 8'h00;
         tx_full             <= 1'b0;
         rx_buffer_reg       <= 8'h00;
         rx_buffer_full_flag <= 1'b0;
         rx_overflow_flag    <= 1'b0;
         ten_bit_match_flag  <= 1'b0;
         clock_release_bit   <= 1'b1;
         rw_bit              <= 1'b0;
         ack_drive           <= 1'b0;
         sda_low             <= 1'b0;
         irq                 <= 1'b0;
         hdr_seen            <= 1'b0;
         rx_load             <= 1'b0;
         rx_nack             <= 1'b0;
         master_nack         <= 1'b0;
      end else begin
         irq <= 1'b0;
         // software side: reads, loads, flag clears (set wins later)
         if (RX_BUFFER_RD_IN) begin
            rx_buffer_full_flag <= 1'b0;
         end
         if (RX_OVERFLOW_CLR_IN) begin
            rx_overflow_flag <= 1'b0;
         end
         if (TX_DATA_WR_IN & ~tx_full) begin
            tx_data_reg <= TX_DATA_IN;
            tx_full     <= 1'b1;
         end
         if (CLOCK_RELEASE_SET_IN) begin
            clock_release_bit <= 1'b1;
         end
         if (!MODULE_ENABLE_BIT_IN) begin
            state     <= ST_IDLE;
            ack_drive <= 1'b0;
            sda_low   <= 1'b0;
            clock_release_bit <= 1'b1;
         end else if (start_det) begin
            // repeated start keeps 10-bit addressed status
            state    <= ST_ADDR;
            bit_cnt  <= 4'h0;
            hdr_seen <= ten_bit_match_flag;
            ack_drive <= 1'b0;
            sda_low  <= 1'b0;
         end else if (stop_det) begin
            state     <= ST_IDLE;
            ack_drive <= 1'b0;
            sda_low   <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  bit_cnt <= 4'h0;
               end
               ST_ADDR, ST_ADLO, ST_RX: begin
                  if (scl_rise && bit_cnt < `ISL_LAST_DATA_BIT) begin
                     rx_shift_reg <= {rx_shift_reg[6:0], sda_s[1]};
                     bit_cnt      <= bit_cnt + 1'b1;
                  end else if (scl_fall &&
                               bit_cnt == `ISL_LAST_DATA_BIT) begin
                     // decide acknowledge for the ninth bit
                     bit_cnt <= `ISL_ACK_BIT;
                     rx_load <= 1'b0;
                     rx_nack <= 1'b0;
                     if (state == ST_ADDR) begin
                        if (hit7 | (hit_hdr & (~rx_shift_reg[0] |
                                               hdr_seen))) begin
                           ack_drive <= 1'b1;
                           sda_low   <= 1'b1;
                        end else begin
                           ten_bit_match_flag <= 1'b0;
                           state <= ST_IDLE;
                        end
                     end else if (state == ST_ADLO) begin
                        if (hit_lo) begin
                           ack_drive <= 1'b1;
                           sda_low   <= 1'b1;
                        end else begin
                           ten_bit_match_flag <= 1'b0;
                           state <= ST_IDLE;
                        end
                     end else if (rx_buffer_full_flag) begin
                        rx_overflow_flag <= 1'b1;
                        rx_nack <= 1'b1;
                     end else if (rx_overflow_flag) begin
                        rx_load <= 1'b1;
                        rx_nack <= 1'b1;
                     end else begin
                        rx_load   <= 1'b1;
                        ack_drive <= 1'b1;
                        sda_low   <= 1'b1;
                     end
                     if (state == ST_RX && !rx_buffer_full_flag) begin
                        rx_buffer_reg <= rx_shift_reg;
                        rx_buffer_full_flag <= 1'b1;
                     end
                  end else if (scl_fall && bit_cnt == `ISL_ACK_BIT) begin
                     // ninth falling edge: pulse and move on
                     ack_drive <= 1'b0;
                     sda_low   <= 1'b0;
                     bit_cnt   <= 4'h0;
                     irq       <= 1'b1;
                     if (state == ST_ADDR) begin
                        rw_bit <= rx_shift_reg[0];
                        if (hit_hdr & ~rx_shift_reg[0]) begin
                           ten_bit_match_flag <= 1'b0;
                           state <= ST_ADLO;
                        end else if (rx_shift_reg[0]) begin
                           state <= ST_TX;
                           if (!tx_full) begin
                              clock_release_bit <= 1'b0;
                           end
                           tx_shift <= tx_data_reg;
                           tx_full  <= 1'b0;
                           sda_low  <= tx_full & ~tx_data_reg[7];
                        end else begin
                           state <= ST_RX;
                        end
                     end else if (state == ST_ADLO) begin
                        ten_bit_match_flag <= 1'b1;
                        state <= ST_RX;
                     end
                     // address bytes leave buffer and full flag alone
                  end
               end
               ST_TX: begin
                  if (scl_fall && bit_cnt < 4'h7) begin
                     // next data bit on each falling edge
                     tx_shift <= {tx_shift[6:0], 1'b0};
                     sda_low  <= ~tx_shift[6];
                     bit_cnt  <= bit_cnt + 1'b1;
                  end else if (scl_fall && bit_cnt == 4'h7) begin
                     sda_low <= 1'b0;
                     bit_cnt <= `ISL_LAST_DATA_BIT;
                  end else if (scl_rise &&
                               bit_cnt == `ISL_LAST_DATA_BIT) begin
                     master_nack <= sda_s[1];
                     bit_cnt     <= `ISL_ACK_BIT;
                  end else if (scl_fall && bit_cnt == `ISL_ACK_BIT) begin
                     irq     <= 1'b1;
                     bit_cnt <= 4'h0;
                     if (master_nack) begin
                        state <= ST_WAIT;
                     end else begin
                        if (!tx_full) begin
                           clock_release_bit <= 1'b0;
                        end
                        tx_shift <= tx_data_reg;
                        tx_full  <= 1'b0;
                        sda_low  <= tx_full & ~tx_data_reg[7];
                     end
                  end
               end
               ST_WAIT: begin
                  sda_low <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
            // data for the held byte arrives before release
            if (state == ST_TX && !clock_release_bit && bit_cnt == 4'h0 &&
                TX_DATA_WR_IN && !tx_full) begin
               tx_shift <= TX_DATA_IN;
               sda_low  <= ~TX_DATA_IN[7];
               tx_full  <= 1'b0;
            end
         end
      end
   end

   // =================================================================
   // receive stream fifo
   // =================================================================
   // each loaded byte also enters the stream fifo
   assign fifo_push = rx_load & (state == ST_RX) & irq;

   isl_fifo #(
      .W  (`ISL_BYTE_W),
      .D  (FIFO_DEPTH),
      .AW (FIFO_AW)
   ) u_fifo (
      .clk_in       (CLK_IN),
      .arst_n_in    (ARST_N_IN),
      .wr_data_in   (rx_buffer_reg),
      .wr_valid_in  (fifo_push),
      .wr_ready_out (fifo_ready),
      .rd_data_out  (RX_STREAM_DATA_OUT),
      .rd_valid_out (RX_STREAM_VALID_OUT),
      .rd_ready_in  (RX_STREAM_READY_IN)
   );

   // =================================================================
   // pin drive and status
   // =================================================================
   // open drain: only drive low, hold scl while released bit clear
   assign SDA_OUT    = 1'b0;
   assign SDA_OE_OUT = sda_low | ack_drive;
   assign SCL_OUT    = 1'b0;
   assign SCL_OE_OUT = (~clock_release_bit & ~scl_s[1]) |
                       (~fifo_ready & (state == ST_RX));

   // status bits are outputs; software clears overflow, clears full by a buffer read and sets the release bit by strobe
   assign RX_BUFFER_OUT            = rx_buffer_reg;
   assign RX_BUFFER_FULL_FLAG_OUT  = rx_buffer_full_flag;
   assign RX_OVERFLOW_FLAG_OUT     = rx_overflow_flag;
   assign TX_BUFFER_FULL_OUT       = tx_full;
   assign TX_DATA_READY_OUT        = ~tx_full;
   assign TEN_BIT_MATCH_FLAG_OUT   = ten_bit_match_flag;
   assign READ_DIRECTION_OUT       = rw_bit;
   assign CLOCK_RELEASE_BIT_OUT    = clock_release_bit;
   assign SLAVE_EVENT_IRQ_FLAG_OUT = irq;
endmodule // isl_slave

// ### include/isl_defines.vh
/*
 * constants for the two-wire slave block: own address reset value,
 * reserved address ranges, 10-bit header pattern and fifo depth.
 * assumes inclusion by bare name from the rtl files.
 */
`ifndef ISL_DEFINES_VH
`define ISL_DEFINES_VH

// =====================================================================
// address layout
// =====================================================================
`define ISL_ADDR_W        10
`define ISL_OWN_ADDR_RST  10'h000
`define ISL_TEN_HDR       5'h1e
`define ISL_RSV_LO_MAX    7'h03
`define ISL_VALID_HI      7'h77
`define ISL_TEN_HI_MAX    7'h7b

// =====================================================================
// data path
// =====================================================================
`define ISL_BYTE_W        8
`define ISL_BIT_CNT_W     4
`define ISL_LAST_DATA_BIT 4'h8
`define ISL_ACK_BIT       4'h9
`define ISL_FIFO_DEPTH    32
`define ISL_BRG_W         16
`define ISL_BRG_RST       16'h0000

`endif

// ### rtl/isl_fifo.v
/*
 * synchronous valid/ready fifo, width and depth parameters.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module isl_fifo #(
   parameter W  = 8,
   parameter D  = 32,
   parameter AW = 5
) (
   input  wire          clk_in,
   input  wire          arst_n_in,
   input  wire [W-1:0]  wr_data_in,
   input  wire          wr_valid_in,
   output wire          wr_ready_out,
   output wire [W-1:0]  rd_data_out,
   output wire          rd_valid_out,
   input  wire          rd_ready_in
);
   reg  [W-1:0] mem [0:D-1];
   reg  [AW-1:0] wp;
   reg  [AW-1:0] rp;
   reg  [AW:0]   cnt;
   wire          push;
   wire          pop;

   // =================================================================
   // flags and pointers
   // =================================================================
   assign wr_ready_out = (cnt != D[AW:0]);
   assign rd_valid_out = (cnt != {(AW+1){1'b0}});
   assign rd_data_out  = mem[rp];
   assign push = wr_valid_in & wr_ready_out;
   assign pop  = rd_valid_out & rd_ready_in;

   // storage write
   always @(posedge clk_in) begin
      if (push) begin
         mem[wp] <= wr_data_in;
      end
   end

   // pointer and count update
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wp  <= {AW{1'b0}};
         rp  <= {AW{1'b0}};
         cnt <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp <= (wp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
         end
         if (pop) begin
            rp <= (rp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
         end
         if (push & ~pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop & ~push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end
endmodule // isl_fifo

// ### sim/isl_slave_props.sv
/* assertions on the two-wire slave top ports.
   assumes it is bound to every isl_slave instance by port name. */
`timescale 1ns/1ps
`include "isl_defines.vh"
module isl_slave_props (
   input wire                   CLK_IN,
   input wire                   ARST_N_IN,
   input wire                   SCL_IN,
   input wire                   SCL_OUT,
   input wire                   SDA_OUT,
   input wire                   SCL_OE_OUT,
   input wire                   SDA_OE_OUT,
   input wire                   MODULE_ENABLE_BIT_IN,
   input wire [`ISL_BYTE_W-1:0] RX_BUFFER_OUT,
   input wire                   RX_BUFFER_FULL_FLAG_OUT,
   input wire                   READ_DIRECTION_OUT,
   input wire                   SLAVE_EVENT_IRQ_FLAG_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   // =================================================================
   // acknowledge steps
   sequence s_ack_begin;
      $rose(SDA_OE_OUT) && !READ_DIRECTION_OUT;
   endsequence
   sequence s_ack_hold;
      SDA_OE_OUT [*6];
   endsequence
   // =================================================================
   // properties
   a_lines_low: assert property (!SCL_OUT && !SDA_OUT)
      else $error("line driven high");
   a_disabled_idle: assert property (!MODULE_ENABLE_BIT_IN [*2] |->
      !SDA_OE_OUT && !SCL_OE_OUT) else $error("lines held while off");
   a_full_no_load: assert property ($changed(RX_BUFFER_OUT) |->
      !$past(RX_BUFFER_FULL_FLAG_OUT)) else $error("loaded while full");
   a_load_sets_full: assert property ($changed(RX_BUFFER_OUT) |->
      RX_BUFFER_FULL_FLAG_OUT) else $error("load without full flag");
   a_irq_one_pulse: assert property (SLAVE_EVENT_IRQ_FLAG_OUT |=>
      !SLAVE_EVENT_IRQ_FLAG_OUT) else $error("event pulse too long");
   a_irq_clock_low: assert property (SLAVE_EVENT_IRQ_FLAG_OUT |->
      !SCL_IN) else $error("event pulse with clock high");
   a_tx_data_stable: assert property ($changed(SDA_OE_OUT) &&
      MODULE_ENABLE_BIT_IN && $past(MODULE_ENABLE_BIT_IN) |-> !SCL_IN)
      else $error("data moved with clock high");
   a_ack_held: assert property (s_ack_begin |-> s_ack_hold)
      else $error("acknowledge cut short");
endmodule // isl_slave_props
bind isl_slave isl_slave_props isl_slave_props_i (.*);

// ### sim/isl_master_model.sv
/* bus master model: start, stop and byte transfers on open-drain lines.
   assumes pulled-up lines, 450 ns bit time, caller on the bench clock. */
`timescale 1ns/1ps
module isl_master_model (
   input  wire clk_in,
   input  wire scl_in,
   input  wire sda_in,
   output reg  scl_low,
   output reg  sda_low,
   output reg  hung
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      hung = 1'b0;
   end
   task wt(input integer n);
      repeat (n) @(posedge clk_in);
   endtask
   // release the clock, bounded wait through any slave stretch
   task rise;
      integer k;
      begin
         scl_low <= 1'b0;
         for (k = 0; k < 1000 && scl_in !== 1'b1; k = k + 1) wt(1);
         if (k == 1000) hung <= 1'b1;
         wt(3);
      end
   endtask
   // data set in the low phase, sampled at end of high
   task bit_io(input b, output s);
      begin
         scl_low <= 1'b1;
         wt(2);
         sda_low <= !b;
         wt(3);
         rise;
         s = sda_in;
      end
   endtask
   task start; // data falls while clock high
      begin sda_low <= 1'b0; wt(2); rise; sda_low <= 1'b1; wt(3); end
   endtask
   task stop;
      begin scl_low <= 1'b1; wt(2); sda_low <= 1'b1; wt(3); rise;
         sda_low <= 1'b0; wt(4); end
   endtask
   // msb first, ninth bit driven by mb, sampled into s
   task xfer(input [7:0] d, input mb, output [7:0] q, output s);
      integer i;
      reg t;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(d[i], t);
            q[i] = t;
         end
         bit_io(mb, s);
         scl_low <= 1'b1;
         wt(6);
      end
   endtask
endmodule // isl_master_model

// ### sim/isl_slave_tb_top.sv
/* bench for the two-wire slave: master model plus software strobes.
   assumes rtl, checker and master model compiled before it. */
`timescale 1ns/1ps
module isl_slave_tb_top;
   reg        clk, arst_n, en, sel, srdy, s;
   reg [9:0]  own;
   reg [15:0] brg;
   reg [7:0]  txd, q, d1, d3;
   reg [5:0]  stb;
   integer    n_fail, compares, n_irq, i0, k, r;
   wire       scl_oe, sda_oe, m_scl, m_sda, hung, sv, ful, ovf, ten, irq;
   wire [7:0] rxb, sd;
   wire       scl = !(m_scl | scl_oe);
   wire       sda = !(m_sda | sda_oe);
   isl_slave isl_slave_i (.CLK_IN(clk), .ARST_N_IN(arst_n), .SCL_IN(scl),
      .SCL_OUT(), .SCL_OE_OUT(scl_oe), .SDA_IN(sda), .SDA_OUT(),
      .SDA_OE_OUT(sda_oe), .MODULE_ENABLE_BIT_IN(en),
      .TEN_BIT_ADDR_SELECT_IN(sel), .OWN_ADDRESS_IN(own),
      .OWN_ADDRESS_WR_IN(stb[0]), .BIT_RATE_RELOAD_IN(brg),
      .BIT_RATE_RELOAD_WR_IN(stb[1]), .BIT_RATE_TICK_OUT(),
      .TX_DATA_IN(txd), .TX_DATA_WR_IN(stb[2]), .TX_DATA_READY_OUT(),
      .CLOCK_RELEASE_SET_IN(stb[3]), .CLOCK_RELEASE_BIT_OUT(),
      .RX_OVERFLOW_CLR_IN(stb[4]), .RX_BUFFER_RD_IN(stb[5]),
      .RX_BUFFER_OUT(rxb), .RX_BUFFER_FULL_FLAG_OUT(ful),
      .RX_OVERFLOW_FLAG_OUT(ovf), .RX_STREAM_DATA_OUT(sd),
      .RX_STREAM_VALID_OUT(sv), .RX_STREAM_READY_IN(srdy),
      .TX_BUFFER_FULL_OUT(), .TEN_BIT_MATCH_FLAG_OUT(ten),
      .READ_DIRECTION_OUT(), .SLAVE_EVENT_IRQ_FLAG_OUT(irq));
   isl_master_model isl_master_model_i (.clk_in(clk), .scl_in(scl),
      .sda_in(sda), .scl_low(m_scl), .sda_low(m_sda), .hung(hung));
   // =================================================================
   // clock and event pulse counter
   initial begin
      clk = 1'b0;
      forever #25 clk = !clk;
   end
   always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;
   // =================================================================
   // helpers
   function automatic [7:0] ack7(input [9:0] o, input [7:0] a);
      ack7 = o[6:0] > 7'h03 && o[6:0] < 7'h78 && a[7:1] == o[6:0];
   endfunction
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         compares = compares + 1;
         if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_fail = n_fail + 1;
         end
      end
   endtask
   task sw(input integer j); // one-cycle software strobe
      begin @(posedge clk); stb[j] <= 1'b1; @(posedge clk); stb <= 6'h00; end
   endtask
   task x(input [7:0] d, input mb);
      isl_master_model_i.xfer(d, mb, q, s);
   endtask
   task complete_run;
      begin
         if (n_fail == 0 && compares > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   // =================================================================
   // main sequence
   initial begin
      arst_n = 1'b0; en = 1'b0; sel = 1'b0; srdy = 1'b0; stb = 6'h00;
      own = 10'h000; brg = 16'h0000; txd = 8'h00;
      n_fail = 0; compares = 0; n_irq = 0;
      r = $urandom(16);
      repeat (2) @(posedge clk);
      arst_n <= 1'b1; en <= 1'b1; brg <= $urandom;
      own <= 10'h004 + $urandom % 116;
      sw(1); sw(0); repeat (4) @(posedge clk);
      // 7-bit write: load, refuse while full, load with overflow set
      d1 = $urandom; d3 = d1 ^ (8'h01 | $urandom); i0 = n_irq;
      isl_master_model_i.start;
      x({own[6:0], 1'b0}, 1'b1); chk("addr ack", 1, !s);
      chk("full after addr", 0, ful);
      x(d1, 1'b1); chk("data ack", 1, !s);
      chk("buffer", d1, rxb); chk("full", 1, ful);
      x(~d1, 1'b1); chk("full ack", 0, !s); chk("kept", d1, rxb);
      chk("overflow", 1, ovf);
      sw(5); x(d3, 1'b1); chk("ovf ack", 0, !s);
      chk("ovf load", d3, rxb); chk("irqs", i0 + 4, n_irq);
      isl_master_model_i.stop; sw(5); sw(4);
      chk("fifo valid", 1, sv); chk("fifo head", d1, sd);
      srdy <= 1'b1;
      // address table: reserved low, reserved high, top valid, mismatch
      for (k = 0; k < 4; k = k + 1) begin
         own <= k==0 ? 10'h002 : k==1 ? 10'h07d : k==2 ? 10'h077 : 10'h3c4;
         sw(0); q = k == 3 ? 8'h0a : {own[6:0], 1'b0}; i0 = n_irq;
         isl_master_model_i.start;
         x(q, 1'b1); chk("table ack", ack7(own, q), !s);
         chk("table irq", i0 + ack7(own, q), n_irq);
         isl_master_model_i.stop;
      end
      // 7-bit read: clock held until load and release
      i0 = n_irq; txd <= $urandom; isl_master_model_i.start;
      x({own[6:0], 1'b1}, 1'b1); chk("read ack", 1, !s);
      chk("rx untouched", d3, rxb);
      fork
         x(8'hff, 1'b1);
         begin repeat (60) @(posedge clk); chk("hold", 1, scl_oe);
            sw(2); sw(3); end
      join
      chk("tx byte", txd, q); chk("tx irq", i0 + 2, n_irq);
      isl_master_model_i.stop;
      // 10-bit: header, low byte, preloaded repeated-start read, mismatch
      sel <= 1'b1; own <= $urandom; sw(0); txd <= $urandom;
      isl_master_model_i.start; x({5'h1e, own[9:8], 1'b0}, 1'b1);
      chk("hdr ack", 1, !s); x(own[7:0], 1'b1); chk("low ack", 1, !s);
      chk("ten flag", 1, ten); sw(2); isl_master_model_i.start;
      x({5'h1e, own[9:8], 1'b1}, 1'b1); chk("restart ack", 1, !s);
      x(8'hff, 1'b1); chk("tx ten", txd, q); isl_master_model_i.stop;
      isl_master_model_i.start; x({5'h1e, own[9:8], 1'b0}, 1'b1);
      x(~own[7:0], 1'b1); chk("nack", 0, !s); chk("ten clr", 0, ten);
      isl_master_model_i.stop;
      en <= 1'b0; repeat (3) @(posedge clk);
      chk("off release", 0, sda_oe); chk("master hung", 0, hung);
      complete_run;
   end
endmodule // isl_slave_tb_top
